/* pkg/rx_pkg.sv */
// constants, register map and field layout for the asynchronous serial receiver
// Summary of operation
// - receive only when enabled, async, port on
// - falling edge on line starts a character
// - start not low at centre: silent abort
// - majority sample each data bit, shift in
// - stop low sets framing error, high clears
// - after stop, buffer character, raise pending flag
// - data read returns oldest, advances buffer
// - pending flag means enabled and unread data
// - interrupt needs all three enables set
// - framing error shown for oldest character
// - port disable resets receiver and errors
// - framing error neither interrupts nor halts
// - third character with buffer full: overrun
// - overrun halts reception, buffer stays readable
// - overrun cleared only by disabling receive/port
// - nine-bit mode: ninth bit shown separately
// - address detect in nine-bit mode keeps only ninth-bit-set characters
// - line sampled at sixteen ticks per bit
package rx_pkg;
  // byte addresses of the apb registers
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  // control register bit positions
  localparam int CTL_PORT_EN = 0;
  localparam int CTL_RX_EN = 1;
  localparam int CTL_SYNC = 2;
  localparam int CTL_NINE = 3;
  localparam int CTL_ADDR_DET = 4;
  localparam int CTL_RX_IE = 5;
  localparam int CTL_PERIPH_IE = 6;
  localparam int CTL_GLOBAL_IE = 7;
  localparam int CTL_WIDTH = 8;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 8'h00;
  // status register bit positions
  localparam int STS_PENDING = 0;
  localparam int STS_FRAMING_ERROR_STATUS = 1;
  localparam int STS_OVERRUN = 2;
  localparam int STS_NINTH = 3;
  localparam int STS_BUSY = 4;
  // buffer entry layout: {framing error, ninth bit, data byte}
  localparam int ENTRY_W = 10;
  localparam int ENT_NINTH = 8;
  localparam int ENT_FRAMING_ERROR_STATUS = 9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // sixteen ticks per bit: two samples then a deciding sample near centre
  localparam logic [3:0] TICK_SAMPLE_A = 4'h7;
  localparam logic [3:0] TICK_SAMPLE_B = 4'h8;
  localparam logic [3:0] TICK_DECIDE = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_e;
endpackage

/* pkg/rx_fifo_if.sv */
// signals between the receiver core and its two-entry character buffer
`timescale 1ns/10ps
`default_nettype none
interface rx_fifo_if;
  import rx_pkg::*;
  logic push; // store push_data this cycle
  logic pop; // drop the oldest entry this cycle
  logic clear; // empty the buffer
  logic [ENTRY_W-1:0] push_data; // entry being stored
  logic [ENTRY_W-1:0] head; // oldest entry
  logic [1:0] count; // entries held
  modport core (output push, output pop, output clear, output push_data,
                input head, input count);
  modport store (input push, input pop, input clear, input push_data,
                 output head, output count);
endinterface
`default_nettype wire

/* hw/rx_fifo2.sv */
// two-entry character buffer with registered storage
`timescale 1ns/10ps
`default_nettype none
module rx_fifo2
  import rx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  rx_fifo_if.store fifo
);
  logic [ENTRY_W-1:0] mem [2]; // storage, one word per character
  logic rd_ptr; // slot of the oldest entry
  logic wr_ptr; // slot for the next entry
  logic [1:0] count; // entries held

  // oldest entry comes straight out of a storage register
  assign fifo.head = mem[rd_ptr];
  assign fifo.count = count;

  // storage write; the core pushes into a full buffer only in a cycle that also pops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else if (fifo.push && !fifo.clear)
    begin
      mem[wr_ptr] <= fifo.push_data;
    end
  end

  // pointers and occupancy; clear wins over everything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end
    else if (fifo.clear)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (fifo.push)
        wr_ptr <= ~wr_ptr;
      if (fifo.pop)
        rd_ptr <= ~rd_ptr;
      if (fifo.push && !fifo.pop)
        count <= count + 2'h1;
      else if (fifo.pop && !fifo.push)
        count <= count - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* hw/async_serial_receiver.sv */
// asynchronous serial receiver with apb registers and two-character buffer
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module async_serial_receiver
  import rx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic baud_tick16,
  input wire logic rx_pin,
  output logic rx_irq
);
  rx_fifo_if fifo ();

  logic [CTL_WIDTH-1:0] control; // software control bits
  logic serial_port_enable; // whole port on
  logic receive_enable_bit; // receiver on
  logic sync_mode; // synchronous mode select, receiver idles when set
  logic nine_bit_receive_select; // nine bits per character
  logic address_detect_enable; // keep only address characters, in nine-bit frames only
  logic rx_active; // asynchronous reception allowed
  logic receive_pending_flag; // unread character while enabled
  logic framing_error_status; // framing flag of the oldest character
  logic overrun_error_status; // sticky overrun
  logic received_ninth_bit; // ninth bit of the oldest character
  logic rx_meta; // first synchroniser stage, read only by rx_sync
  logic rx_sync; // synchronised line
  logic rx_prev; // line one cycle back, for edge detection
  logic fall_edge; // high-to-low transition seen
  rx_state_e state; // framing state
  logic [3:0] tick_cnt; // position inside the current bit
  logic [3:0] bit_cnt; // data bits taken so far
  logic frame_nine; // width of the frame in flight
  logic samp_a; // first majority sample
  logic samp_b; // second majority sample
  logic decide; // deciding tick of the current bit
  logic bit_val; // majority result
  logic [8:0] receive_shift_register; // assembled bits, lsb first
  logic [7:0] char_data; // data byte of the finished frame
  logic char_ninth; // ninth bit of the finished frame
  logic stop_done; // stop bit decided this cycle
  logic char_keep; // finished frame passes the address filter
  logic fifo_full; // no room even after this cycle's pop
  logic apb_setup; // first phase of a transfer
  logic apb_access; // completing phase of a transfer
  logic addr_known; // address maps to a register
  logic rd_valid; // data read found a character at setup
  logic pop_now; // data read completes and removes a character

  // control field split
  assign serial_port_enable = control[CTL_PORT_EN];
  assign receive_enable_bit = control[CTL_RX_EN];
  assign sync_mode = control[CTL_SYNC];
  assign nine_bit_receive_select = control[CTL_NINE];
  assign address_detect_enable = control[CTL_ADDR_DET];
  assign rx_active = receive_enable_bit & ~sync_mode & serial_port_enable;

  // majority of three samples
  function automatic logic majority3(input logic a, input logic b, input logic c);
    majority3 = (a & b) | (a & c) | (b & c);
  endfunction

  // line synchroniser; the remote transmitter shares no clock with us
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign fall_edge = rx_prev & ~rx_sync;
  assign decide = baud_tick16 && (tick_cnt == TICK_DECIDE);
  assign bit_val = majority3(samp_a, samp_b, rx_sync);
  assign stop_done = (state == ST_STOP) && decide;

  // framing state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else if (!rx_active)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          // an overrun freezes reception until software clears it
          if (fall_edge && !overrun_error_status)
            state <= ST_START;
        ST_START:
          if (decide)
            state <= bit_val ? ST_IDLE : ST_DATA;
        ST_DATA:
          if (decide && (bit_cnt == (frame_nine ? BITS_NINE : BITS_EIGHT) - 4'h1))
            state <= ST_STOP;
        ST_STOP:
          if (decide)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // sixteen-tick bit timer, restarted at the start edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt <= 4'h0;
    else if (state == ST_IDLE)
      tick_cnt <= 4'h0;
    else if (baud_tick16)
      tick_cnt <= tick_cnt + 4'h1;
  end

  // majority samples just before the deciding tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      samp_a <= 1'b1;
      samp_b <= 1'b1;
    end
    else if (baud_tick16)
    begin
      if (tick_cnt == TICK_SAMPLE_A)
        samp_a <= rx_sync;
      if (tick_cnt == TICK_SAMPLE_B)
        samp_b <= rx_sync;
    end
  end

  // shift register advances once per data bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_shift_register <= 9'h000;
      bit_cnt <= 4'h0;
      frame_nine <= 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      bit_cnt <= 4'h0;
      frame_nine <= nine_bit_receive_select;
    end
    else if ((state == ST_DATA) && decide)
    begin
      receive_shift_register <= {bit_val, receive_shift_register[8:1]};
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // eight-bit frames end one place higher in the shift register
  assign char_data = frame_nine ? receive_shift_register[7:0] : receive_shift_register[8:1];
  assign char_ninth = frame_nine & receive_shift_register[8];
  assign char_keep = !(address_detect_enable && frame_nine) || char_ninth;
  assign fifo_full = (fifo.count == FIFO_DEPTH) && !pop_now;

  // hand finished characters to the buffer
  assign fifo.push = stop_done && char_keep && !fifo_full && rx_active;
  assign fifo.push_data = {~bit_val, char_ninth, char_data};
  assign fifo.pop = pop_now;
  assign fifo.clear = !serial_port_enable;

  rx_fifo2 u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .fifo(fifo)
  );

  // overrun: set wins over the clear, which is receiver or port disable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_error_status <= 1'b0;
    else if (stop_done && char_keep && fifo_full && rx_active)
      overrun_error_status <= 1'b1;
    else if (!receive_enable_bit || !serial_port_enable)
      overrun_error_status <= 1'b0;
  end

  // visible status follows the oldest unread entry
  assign receive_pending_flag = rx_active && (fifo.count != 2'h0);
  assign framing_error_status = (fifo.count != 2'h0) && fifo.head[ENT_FRAMING_ERROR_STATUS];
  assign received_ninth_bit = (fifo.count != 2'h0) && fifo.head[ENT_NINTH];
  assign rx_irq = receive_pending_flag & control[CTL_RX_IE] & control[CTL_PERIPH_IE]
                  & control[CTL_GLOBAL_IE];

  // apb decode; the slave never inserts wait states
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_known = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS)
                      || (paddr == ADDR_DATA);
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_known;
  // pop only what was captured at setup, so no character is lost unseen
  assign pop_now = apb_access && !pwrite && (paddr == ADDR_DATA) && rd_valid;

  // control register write; status and data are read-only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control <= CTL_RESET;
    else if (apb_access && pwrite && (paddr == ADDR_CONTROL))
      control <= pwdata[CTL_WIDTH-1:0];
  end

  // read data captured in the setup phase, held through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end
    else if (apb_setup)
    begin
      rd_valid <= !pwrite && (paddr == ADDR_DATA) && (fifo.count != 2'h0);
      prdata <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          ADDR_CONTROL:
            prdata[CTL_WIDTH-1:0] <= control;
          ADDR_STATUS:
          begin
            prdata[STS_PENDING] <= receive_pending_flag;
            prdata[STS_FRAMING_ERROR_STATUS] <= framing_error_status;
            prdata[STS_OVERRUN] <= overrun_error_status;
            prdata[STS_NINTH] <= received_ninth_bit;
            prdata[STS_BUSY] <= (state != ST_IDLE);
          end
          ADDR_DATA:
            if (fifo.count != 2'h0)
              prdata[7:0] <= fifo.head[7:0];
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
    else if (apb_access)
      rd_valid <= 1'b0;
  end

  // checks on the receiver's own behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // while reception stays on, the flag may move only with a push or a pop, so status and data writes cannot touch it
  property p_pending;
    rx_active && $past(rx_active) && !$past(fifo.push) && !$past(pop_now)
      |-> receive_pending_flag == $past(receive_pending_flag);
  endproperty
  a_pending: assert property (p_pending) else $error("pending flag wrong");

  property p_start_abort;
    (state == ST_START) && decide && bit_val && rx_active |=> (state == ST_IDLE) && !fifo.push;
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("bad start kept");

  property p_port_off;
    !serial_port_enable |=> (fifo.count == 2'h0) && !overrun_error_status
                            && !framing_error_status && (state == ST_IDLE);
  endproperty
  a_port_off: assert property (p_port_off) else $error("port disable no reset");

  property p_overrun_hold;
    overrun_error_status && rx_active && (state == ST_IDLE) |=> state == ST_IDLE;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("rx during overrun");

  property p_overrun_set;
    stop_done && char_keep && fifo_full && rx_active |=> overrun_error_status
                                                        && (fifo.count == FIFO_DEPTH);
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun missed");

  property p_irq;
    rx_irq == (receive_pending_flag && control[CTL_RX_IE] && control[CTL_PERIPH_IE]
               && control[CTL_GLOBAL_IE]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gating wrong");

  property p_push_pending;
    fifo.push && !pop_now && serial_port_enable |=> (fifo.count != 2'h0)
                                                    && (receive_pending_flag == rx_active);
  endproperty
  a_push_pending: assert property (p_push_pending) else $error("push lost");

  property p_addr_filter;
    fifo.push && address_detect_enable && frame_nine |-> fifo.push_data[ENT_NINTH];
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("data char kept");

  property p_pop_count;
    pop_now && !fifo.push && serial_port_enable |=> fifo.count == $past(fifo.count) - 2'h1;
  endproperty
  a_pop_count: assert property (p_pop_count) else $error("read did not advance");

  property p_framing_error_status_push;
    fifo.push && (fifo.count == 2'h0) && serial_port_enable
      |=> framing_error_status == $past(fifo.push_data[ENT_FRAMING_ERROR_STATUS]);
  endproperty
  a_framing_error_status_push: assert property (p_framing_error_status_push) else $error("framing flag wrong");
endmodule
`default_nettype wire

/* testbench/serial_tx_model.sv */
// behavioural remote transmitter driving the shared receive line
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model
(
  input wire logic pclk,
  input wire logic tick,
  input wire logic go,
  input wire logic [8:0] data,
  input wire logic nine,
  input wire logic stop_val,
  input wire logic glitch,
  output logic line,
  output logic busy
);
  logic [10:0] frame; // bits still to go out, lsb next
  logic [3:0] left; // bits left in this frame, current one included
  logic [3:0] ticks; // ticks spent in the current bit
  logic [3:0] last; // last tick index of each bit
  // line idles high like a marking line, so the receiver never sees a stale low
  initial
  begin
    line = 1'b1;
    busy = 1'b0;
  end
  // start a frame, then step one bit every sixteen ticks
  always @(posedge pclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      ticks <= 4'h0;
      // a glitch is a low pulse of four ticks, shorter than half a bit
      last <= glitch ? 4'h3 : 4'hF;
      left <= glitch ? 4'h1 : (nine ? 4'hB : 4'hA);
      line <= 1'b0;
      // data lsb first, ninth bit last, then the stop level
      frame <= nine ? {1'b1, stop_val, data} : {2'b11, stop_val, data[7:0]};
    end
    else if (busy && tick)
    begin
      if (ticks != last)
        ticks <= ticks + 4'h1;
      else if (left == 4'h1)
      begin
        // frame over: release to idle high
        busy <= 1'b0;
        line <= 1'b1;
      end
      else
      begin
        ticks <= 4'h0;
        left <= left - 4'h1;
        line <= frame[0];
        frame <= {1'b1, frame[10:1]};
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/async_serial_receiver_bench.sv */
// self-checking bench for the asynchronous serial receiver
`timescale 1ns/10ps
`default_nettype none
module async_serial_receiver_bench;
  import rx_pkg::*;
  logic pclk = 1'b0; // 25 MHz bus clock
  logic presetn; // active-low reset
  logic psel, penable, pwrite; // apb request
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, rnd;
  logic pready, pslverr, slverr, rx_irq, baud_tick16, rx_pin;
  logic go, nine, stopv, glitch, busy; // transmitter model controls
  logic [8:0] txd; // character for the model
  logic [7:0] b [0:2]; // characters in flight
  logic fe [0:1]; // framing error per character
  int errors = 0;
  int comparisons = 0;
  localparam logic [31:0] PORT = 32'h1 << CTL_PORT_EN;
  localparam logic [31:0] RUN = PORT | (32'h1 << CTL_RX_EN);
  localparam logic [31:0] SYNCB = 32'h1 << CTL_SYNC;
  localparam logic [31:0] NINE = 32'h1 << CTL_NINE;
  localparam logic [31:0] ADET = 32'h1 << CTL_ADDR_DET;
  // clock and a 16x tick every other cycle keep a bit at 32 clocks
  always #20 pclk = ~pclk;
  always @(posedge pclk) baud_tick16 <= ~baud_tick16;
  async_serial_receiver async_serial_receiver_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .baud_tick16(baud_tick16), .rx_pin(rx_pin),
    .rx_irq(rx_irq));
  serial_tx_model serial_tx_model_i (.pclk(pclk), .tick(baud_tick16), .go(go), .data(txd),
    .nine(nine), .stop_val(stopv), .glitch(glitch), .line(rx_pin), .busy(busy));
  // random source with a fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected status word; busy is zero between frames
  function automatic logic [31:0] sts(input logic p, input logic f, input logic o, input logic n);
    sts = 32'h0;
    sts[STS_PENDING] = p;
    sts[STS_FRAMING_ERROR_STATUS] = f;
    sts[STS_OVERRUN] = o;
    sts[STS_NINTH] = n;
  endfunction
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      errors++;
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp32(rdata, e);
  endtask
  // one frame from the model, waited out under a bound
  task automatic send(input logic [8:0] d, input logic n, input logic s, input logic g);
    int k;
    @(posedge pclk);
    txd <= d;
    nine <= n;
    stopv <= s;
    glitch <= g;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    k = 0;
    while (busy === 1'b1 && k < 1000)
    begin
      @(posedge pclk);
      k++;
    end
    // a model stuck in a frame counts as a mismatch
    if (busy === 1'b1)
      errors++;
    // a short pulse is only judged ten ticks after its edge, so idle well past that
    repeat (40) @(posedge pclk);
  endtask
  // hang guard: nearly four times the expected run
  initial
  begin
    repeat (30000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    baud_tick16 = 1'b0;
    go = 1'b0;
    txd = 9'h000;
    nine = 1'b0;
    stopv = 1'b1;
    glitch = 1'b0;
    rnd = 32'hA5E76FBF;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(ADDR_CONTROL, 32'h0);
    chk(ADDR_STATUS, 32'h0);
    chk(12'hFFC, 32'h0);
    cmp1(slverr, 1'b1);
    // synchronous mode selected: nothing may arrive
    wr(ADDR_CONTROL, RUN | SYNCB);
    send(9'h055, 1'b0, 1'b1, 1'b0);
    chk(ADDR_STATUS, 32'h0);
    wr(ADDR_CONTROL, RUN);
    // pairs of characters; first pair is all zeros then all ones
    for (int r = 0; r < 4; r++)
    begin
      for (int j = 0; j < 2; j++)
      begin
        rnd = lfsr(rnd);
        b[j] = (r == 0) ? {8{j[0]}} : rnd[7:0];
        fe[j] = (r == 0) ? ~j[0] : rnd[8];
        send({1'b0, b[j]}, 1'b0, ~fe[j], 1'b0);
      end
      for (int j = 0; j < 2; j++)
      begin
        chk(ADDR_STATUS, sts(1'b1, fe[j], 1'b0, 1'b0));
        chk(ADDR_DATA, {24'h0, b[j]});
      end
      chk(ADDR_STATUS, 32'h0);
    end
    // interrupt needs all three enables; flag ignores them
    send(9'h0A5, 1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      wr(ADDR_CONTROL, RUN | (32'(k) << CTL_RX_IE));
      @(posedge pclk);
      cmp1(rx_irq, k == 7);
    end
    wr(ADDR_STATUS, 32'hFF);
    wr(ADDR_DATA, 32'h0);
    chk(ADDR_STATUS, sts(1'b1, 1'b0, 1'b0, 1'b0));
    chk(ADDR_DATA, 32'hA5);
    @(posedge pclk);
    cmp1(rx_irq, 1'b0);
    wr(ADDR_CONTROL, RUN);
    // third character overruns; fourth is not taken
    for (int j = 0; j < 3; j++)
    begin
      rnd = lfsr(rnd);
      b[j] = rnd[7:0];
      send({1'b0, b[j]}, 1'b0, 1'b1, 1'b0);
    end
    chk(ADDR_STATUS, sts(1'b1, 1'b0, 1'b1, 1'b0));
    send(9'h03C, 1'b0, 1'b1, 1'b0);
    chk(ADDR_DATA, {24'h0, b[0]});
    chk(ADDR_DATA, {24'h0, b[1]});
    chk(ADDR_STATUS, sts(1'b0, 1'b0, 1'b1, 1'b0));
    chk(ADDR_DATA, 32'h0);
    wr(ADDR_CONTROL, PORT);
    wr(ADDR_CONTROL, RUN);
    chk(ADDR_STATUS, 32'h0);
    send(9'h0C3, 1'b0, 1'b1, 1'b0);
    chk(ADDR_DATA, 32'hC3);
    // receive disable keeps the framing error, port disable clears it
    send(9'h081, 1'b0, 1'b0, 1'b0);
    wr(ADDR_CONTROL, PORT);
    chk(ADDR_STATUS, sts(1'b0, 1'b1, 1'b0, 1'b0));
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_CONTROL, RUN);
    chk(ADDR_STATUS, 32'h0);
    chk(ADDR_DATA, 32'h0);
    // nine-bit characters and the address filter
    wr(ADDR_CONTROL, RUN | NINE);
    send(9'h1E7, 1'b1, 1'b1, 1'b0);
    chk(ADDR_STATUS, sts(1'b1, 1'b0, 1'b0, 1'b1));
    chk(ADDR_DATA, 32'hE7);
    wr(ADDR_CONTROL, RUN | NINE | ADET);
    send(9'h07E, 1'b1, 1'b1, 1'b0);
    chk(ADDR_STATUS, 32'h0);
    send(9'h12D, 1'b1, 1'b1, 1'b0);
    chk(ADDR_STATUS, sts(1'b1, 1'b0, 1'b0, 1'b1));
    chk(ADDR_DATA, 32'h2D);
    wr(ADDR_CONTROL, RUN | NINE);
    send(9'h07E, 1'b1, 1'b1, 1'b0);
    chk(ADDR_STATUS, sts(1'b1, 1'b0, 1'b0, 1'b0));
    chk(ADDR_DATA, 32'h7E);
    // short low pulse is dropped, next frame still lands alone
    // address detect without nine-bit frames must keep every character
    wr(ADDR_CONTROL, RUN | ADET);
    send(9'h000, 1'b0, 1'b1, 1'b1);
    chk(ADDR_STATUS, 32'h0);
    send(9'h05A, 1'b0, 1'b1, 1'b0);
    chk(ADDR_DATA, 32'h5A);
    chk(ADDR_STATUS, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
